// [verilog/dout_cond_top.sv]
// Purpose: Decides when each of three discrete outputs goes active.
// Assumes: APB slave, one wait state; reader inputs synchronous to clk.
// Notes: Service timer is shared; per-output settings are independent.
`timescale 1ns/1ps
module dout_cond_top #(
    parameter int SEC_CYCLES = dout_pkg::SEC_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // APB slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Reader events
    input wire logic decode_done,
    input wire logic match,
    input wire logic mismatch,
    input wire logic no_read,
    input wire logic [dout_pkg::NUM_OUT-1:0] trend_event,
    input wire logic in_read_cycle,
    input wire logic capture_active,
    input wire logic diag_warning,
    input wire logic continuous_mode,
    input wire logic [dout_pkg::THR_W-1:0] grade_meas,
    // Discrete outputs and interrupt
    output logic [dout_pkg::NUM_OUT-1:0] discrete_out,
    output logic irq
);
    localparam int N = dout_pkg::NUM_OUT;

    logic [3:0] sel_q [N];
    logic [N-1:0] diag_en_q;
    logic [N-1:0] svc_en_q;
    logic [dout_pkg::NUM_MET-1:0] dpm_en_q [N];
    logic [dout_pkg::THR_W-1:0] dpm_thr_q [N];
    logic [15:0] svc_limit_q;
    logic svc_res_q;
    logic [dout_pkg::IRQ_W-1:0] irq_status_q;
    logic [dout_pkg::IRQ_W-1:0] irq_mask_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic [N-1:0] out_q;
    logic [N-1:0] out_d;
    logic [N-1:0] qual_fail;
    logic [N-1:0] result_q;
    logic irq_q;
    logic [31:0] sec_cnt_q;
    logic [5:0] min_cnt_q;
    logic [15:0] svc_cnt_q;
    dout_pkg::svc_state_type svc_state_q;
    logic sec_tick;
    logic tick;
    logic svc_active;
    logic svc_expire;
    logic wr;
    logic acc;
    logic [31:0] rd_data;
    logic rd_err;

    // Outcome of a decode for the latched selector codes
    function automatic logic decode_result(input logic [3:0] sel, input logic m, input logic mm,
                                           input logic nr, input logic tr);
        case (sel)
            dout_pkg::SEL_MISS_OR_NOREAD: decode_result = mm | nr;
            dout_pkg::SEL_MATCH: decode_result = m;
            dout_pkg::SEL_MISMATCH: decode_result = mm;
            dout_pkg::SEL_NOREAD: decode_result = nr;
            dout_pkg::SEL_TREND: decode_result = tr;
            default: decode_result = 1'b0;
        endcase
    endfunction

    // Per-output register slot in the low address space
    function automatic logic in_out_space(input logic [7:0] a);
        in_out_space = (a < dout_pkg::OFS_SVC_LIMIT) && (a[1:0] == 2'b00) && (a[3:0] <= dout_pkg::OFS_DPM_THR[3:0]);
    endfunction

    assign acc = psel && penable && pready_q;
    assign wr = acc && pwrite;

    // APB handshake: one wait state, then answer from flops
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else if (psel && penable && !pready_q) begin
            pready_q <= 1'b1;
            pslverr_q <= rd_err;
            prdata_q <= pwrite ? 32'h0000_0000 : rd_data;
        end else begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    // Read decode
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_err = 1'b0;
        if (in_out_space(paddr)) begin
            if (paddr[3:0] == dout_pkg::OFS_CFG[3:0]) begin
                rd_data[5:0] = {svc_en_q[paddr[5:4]], diag_en_q[paddr[5:4]], sel_q[paddr[5:4]]};
            end else if (paddr[3:0] == dout_pkg::OFS_DPM_EN[3:0]) begin
                rd_data[dout_pkg::NUM_MET-1:0] = dpm_en_q[paddr[5:4]];
            end else begin
                rd_data[dout_pkg::THR_W-1:0] = dpm_thr_q[paddr[5:4]];
            end
        end else if (paddr == dout_pkg::OFS_SVC_LIMIT) begin
            rd_data[15:0] = svc_limit_q;
        end else if (paddr == dout_pkg::OFS_SVC_RES) begin
            rd_data[0] = svc_res_q;
        end else if (paddr == dout_pkg::OFS_IRQ_STATUS) begin
            rd_data[dout_pkg::IRQ_W-1:0] = irq_status_q;
        end else if (paddr == dout_pkg::OFS_IRQ_MASK) begin
            rd_data[dout_pkg::IRQ_W-1:0] = irq_mask_q;
        end else if (paddr == dout_pkg::OFS_STATE) begin
            rd_data[N:0] = {svc_active, out_q};
        end else begin
            rd_err = 1'b1;
        end
    end

    // Per-output configuration, one copy per output
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            for (int k = 0; k < N; k++) begin
                sel_q[k] <= dout_pkg::SEL_RST;
                diag_en_q[k] <= 1'b0;
                svc_en_q[k] <= 1'b0;
                dpm_en_q[k] <= '0;
                dpm_thr_q[k] <= dout_pkg::DPM_THR_RST;
            end
        end else if (wr && in_out_space(paddr)) begin
            if (paddr[3:0] == dout_pkg::OFS_CFG[3:0]) begin
                if (pwdata[3:0] <= dout_pkg::SEL_STROBE) begin
                    sel_q[paddr[5:4]] <= pwdata[3:0];
                end
                diag_en_q[paddr[5:4]] <= pwdata[dout_pkg::CFG_DIAG_BIT];
                svc_en_q[paddr[5:4]] <= pwdata[dout_pkg::CFG_SVC_BIT];
            end else if (paddr[3:0] == dout_pkg::OFS_DPM_EN[3:0]) begin
                dpm_en_q[paddr[5:4]] <= pwdata[dout_pkg::NUM_MET-1:0];
            end else begin
                dpm_thr_q[paddr[5:4]] <= pwdata[dout_pkg::THR_W-1:0];
            end
        end
    end

    // Service timer settings; a zero limit is raised to the minimum
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            svc_limit_q <= dout_pkg::SVC_LIMIT_RST;
            svc_res_q <= 1'b0;
        end else if (wr && paddr == dout_pkg::OFS_SVC_LIMIT) begin
            svc_limit_q <= (pwdata[15:0] == 16'h0000) ? dout_pkg::SVC_LIMIT_MIN : pwdata[15:0];
        end else if (wr && paddr == dout_pkg::OFS_SVC_RES) begin
            svc_res_q <= pwdata[0];
        end
    end

    // Second and minute prescalers
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sec_cnt_q <= 32'h0000_0000;
            min_cnt_q <= 6'h00;
        end else begin
            sec_cnt_q <= sec_tick ? 32'h0000_0000 : sec_cnt_q + 32'h0000_0001;
            if (sec_tick) begin
                min_cnt_q <= (min_cnt_q == dout_pkg::SEC_PER_MIN - 6'h01) ? 6'h00 : min_cnt_q + 6'h01;
            end
        end
    end

    assign sec_tick = (sec_cnt_q == 32'(SEC_CYCLES - 1));
    assign tick = sec_tick && (!svc_res_q || min_cnt_q == dout_pkg::SEC_PER_MIN - 6'h01);
    assign svc_active = (svc_state_q == dout_pkg::SVC_HOLD);
    assign svc_expire = (svc_state_q == dout_pkg::SVC_COUNT) && tick && (svc_cnt_q + 16'h0001 >= svc_limit_q);

    // Service timer: count increments, then hold active for one increment
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            svc_state_q <= dout_pkg::SVC_COUNT;
            svc_cnt_q <= 16'h0000;
        end else begin
            case (svc_state_q)
                dout_pkg::SVC_COUNT: begin
                    if (svc_expire) begin
                        svc_state_q <= dout_pkg::SVC_HOLD;
                        svc_cnt_q <= 16'h0000;
                    end else if (tick) begin
                        svc_cnt_q <= svc_cnt_q + 16'h0001;
                    end
                end
                dout_pkg::SVC_HOLD: begin
                    if (tick) begin
                        svc_state_q <= dout_pkg::SVC_COUNT;
                    end
                end
                default: begin
                    svc_state_q <= dout_pkg::SVC_COUNT;
                end
            endcase
        end
    end

    // Per-output condition logic
    for (genvar j = 0; j < N; j++) begin : g_out
        grade_check u_grade (
            .clk(clk),
            .rst_b(rst_b),
            .sample(decode_done),
            .en(dpm_en_q[j]),
            .thr(dpm_thr_q[j]),
            .grade(grade_meas),
            .fail_q(qual_fail[j])
        );

        // Decode outcome held until the next decode
        always_ff @(posedge clk) begin
            if (!rst_b) begin
                result_q[j] <= 1'b0;
            end else if (decode_done) begin
                result_q[j] <= decode_result(sel_q[j], match, mismatch, no_read, trend_event[j]);
            end
        end

        // Diagnostic mode wins; else selector, plus service pulse
        always_comb begin
            logic sel_hit;
            sel_hit = 1'b0;
            case (sel_q[j])
                dout_pkg::SEL_QUALITY: sel_hit = qual_fail[j];
                dout_pkg::SEL_DIAG: sel_hit = diag_warning;
                dout_pkg::SEL_IN_CYCLE: sel_hit = in_read_cycle;
                dout_pkg::SEL_STROBE: sel_hit = capture_active;
                default: sel_hit = result_q[j];
            endcase
            if (diag_en_q[j]) begin
                out_d[j] = diag_warning;
            end else begin
                // Continuous mode is gated here too, though the host should never combine them
                out_d[j] = sel_hit || (svc_en_q[j] && svc_active && !continuous_mode);
            end
        end

        property p_diag_on;
            @(posedge clk) disable iff (!rst_b) diag_en_q[j] && diag_warning |=> out_q[j];
        endproperty
        a_diag_on: assert property (p_diag_on) else $error("diag warning not driven");

        property p_diag_off;
            @(posedge clk) disable iff (!rst_b) diag_en_q[j] && !diag_warning |=> !out_q[j];
        endproperty
        a_diag_off: assert property (p_diag_off) else $error("output held with no warning");

        property p_strobe;
            @(posedge clk) disable iff (!rst_b)
                !diag_en_q[j] && !svc_en_q[j] && sel_q[j] == dout_pkg::SEL_STROBE |=> out_q[j] == $past(capture_active);
        endproperty
        a_strobe: assert property (p_strobe) else $error("strobe not tied to capture");

        property p_svc_out;
            @(posedge clk) disable iff (!rst_b)
                !diag_en_q[j] && svc_en_q[j] && svc_active && !continuous_mode |=> out_q[j];
        endproperty
        a_svc_out: assert property (p_svc_out) else $error("service expiry not driven");

        property p_sel_range;
            @(posedge clk) disable iff (!rst_b) sel_q[j] <= dout_pkg::SEL_STROBE;
        endproperty
        a_sel_range: assert property (p_sel_range) else $error("selector out of range");

        property p_reset_cfg;
            @(posedge clk) !rst_b |=> dpm_en_q[j] == '0 && dpm_thr_q[j] == dout_pkg::DPM_THR_RST && sel_q[j] == 4'h0;
        endproperty
        a_reset_cfg: assert property (p_reset_cfg) else $error("bad reset config");
    end

    // Outputs, sticky status with set winning over clear, interrupt
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            out_q <= '0;
            irq_status_q <= '0;
            irq_mask_q <= '0;
            irq_q <= 1'b0;
        end else begin
            out_q <= out_d;
            irq_status_q <= (irq_status_q & ~((wr && paddr == dout_pkg::OFS_IRQ_STATUS) ?
                             pwdata[dout_pkg::IRQ_W-1:0] : 4'h0)) | {svc_expire, out_d & ~out_q};
            if (wr && paddr == dout_pkg::OFS_IRQ_MASK) begin
                irq_mask_q <= pwdata[dout_pkg::IRQ_W-1:0];
            end
            irq_q <= |(irq_status_q & irq_mask_q);
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign discrete_out = out_q;
    assign irq = irq_q;

    property p_hold_one_tick;
        @(posedge clk) disable iff (!rst_b) svc_active && tick |=> !svc_active;
    endproperty
    a_hold_one_tick: assert property (p_hold_one_tick) else $error("service hold too long");

    property p_hold_start;
        @(posedge clk) disable iff (!rst_b) svc_expire |=> svc_active && svc_cnt_q == 16'h0000;
    endproperty
    a_hold_start: assert property (p_hold_start) else $error("service hold missing");

    property p_limit_min;
        @(posedge clk) disable iff (!rst_b) svc_limit_q >= dout_pkg::SVC_LIMIT_MIN;
    endproperty
    a_limit_min: assert property (p_limit_min) else $error("service limit below one");

    c_svc: cover property (@(posedge clk) disable iff (!rst_b) svc_expire);
    c_diag: cover property (@(posedge clk) disable iff (!rst_b) diag_en_q[0] && diag_warning ##1 !diag_warning);
    c_quality: cover property (@(posedge clk) disable iff (!rst_b) qual_fail[1] && sel_q[1] == dout_pkg::SEL_QUALITY);
    c_irq: cover property (@(posedge clk) disable iff (!rst_b) $rose(irq_q));
endmodule // dout_cond_top

// [verilog/dout_pkg.sv]
// Purpose: Constants for the discrete output condition logic.
// Assumes: 250 MHz clock, APB register access, three discrete outputs.
// Notes: Timing constants assume a single clock domain.
package dout_pkg;
    localparam int NUM_OUT = 3;
    localparam int NUM_MET = 7;
    localparam int GRADE_W = 2;
    localparam int THR_W = NUM_MET * GRADE_W;
    // Output-on selector codes
    typedef enum logic [3:0] {
        SEL_MISS_OR_NOREAD = 4'h0,
        SEL_MATCH = 4'h1,
        SEL_MISMATCH = 4'h2,
        SEL_NOREAD = 4'h3,
        SEL_TREND = 4'h4,
        SEL_QUALITY = 4'h5,
        SEL_DIAG = 4'h6,
        SEL_IN_CYCLE = 4'h7,
        SEL_STROBE = 4'h8
    } sel_type;
    // Service timer states
    typedef enum logic [1:0] {
        SVC_COUNT = 2'b00,
        SVC_HOLD = 2'b01
    } svc_state_type;
    // Register byte offsets
    localparam logic [7:0] OUT_STRIDE = 8'h10;
    localparam logic [7:0] OFS_CFG = 8'h00;
    localparam logic [7:0] OFS_DPM_EN = 8'h04;
    localparam logic [7:0] OFS_DPM_THR = 8'h08;
    localparam logic [7:0] OFS_SVC_LIMIT = 8'h30;
    localparam logic [7:0] OFS_SVC_RES = 8'h34;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h38;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h3c;
    localparam logic [7:0] OFS_STATE = 8'h40;
    // Field positions and widths in the per-output config word and the interrupt words
    localparam int CFG_SEL_LSB = 0;
    localparam int CFG_DIAG_BIT = 4;
    localparam int CFG_SVC_BIT = 5;
    localparam int IRQ_SVC_BIT = 3;
    localparam int IRQ_W = 4;
    // Reset values and the service limit minimum
    localparam logic [3:0] SEL_RST = 4'h0;
    localparam logic [GRADE_W-1:0] GRADE_THR_RST = 2'h2;
    localparam logic [THR_W-1:0] DPM_THR_RST = {NUM_MET{GRADE_THR_RST}};
    localparam logic [15:0] SVC_LIMIT_RST = 16'h012c;
    localparam logic [15:0] SVC_LIMIT_MIN = 16'h0001;
    // Timing
    localparam longint SECOND_NS = 1000000000;
    localparam longint CLK_PERIOD_NS = 4;
    localparam int SEC_CYCLES = int'(SECOND_NS / CLK_PERIOD_NS);
    localparam logic [5:0] SEC_PER_MIN = 6'h3c;
endpackage

// [verilog/grade_check.sv]
// Purpose: One direct-mark grade check set for one discrete output.
// Assumes: Grades are sampled on a one-cycle decode strobe.
// Notes: Result holds until the next decode.
`timescale 1ns/1ps
module grade_check (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Check configuration and measurement
    input wire logic sample,
    input wire logic [dout_pkg::NUM_MET-1:0] en,
    input wire logic [dout_pkg::THR_W-1:0] thr,
    input wire logic [dout_pkg::THR_W-1:0] grade,
    // Combined result
    output logic fail_q
);
    logic [dout_pkg::NUM_MET-1:0] below;

    // Per-metric compare against its threshold grade
    for (genvar i = 0; i < dout_pkg::NUM_MET; i++) begin : g_met
        assign below[i] = en[i] && (grade[i*2 +: 2] < thr[i*2 +: 2]);
    end

    // OR of enabled results, caught once per decode
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            fail_q <= 1'b0;
        end else if (sample) begin
            fail_q <= |below;
        end
    end

    property p_fail_on_low;
        @(posedge clk) disable iff (!rst_b) sample && (|below) |=> fail_q;
    endproperty
    a_fail_on_low: assert property (p_fail_on_low) else $error("grade below threshold not flagged");

    property p_no_fail_clean;
        @(posedge clk) disable iff (!rst_b) sample && !(|below) |=> !fail_q ##1 ($past(sample) || !fail_q);
    endproperty
    a_no_fail_clean: assert property (p_no_fail_clean) else $error("false quality fail");
endmodule // grade_check

// [bench/relay_model.sv]
// Purpose: Relay or PLC input load on the three discrete lines.
// Assumes: Lines are active-high levels synchronous to clk.
// Notes: Times the width of each pulse on line 1 for the bench.
`timescale 1ns/1ps
module relay_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Discrete lines from the block
    input wire logic [2:0] line_in,
    // Observed coil state and pulse timing
    output logic [2:0] coil_q,
    output logic [15:0] run_q,
    output logic [15:0] last_len_q,
    output logic [7:0] pulses_q
);
    // Coil follows the line a cycle late; line 1 pulses are measured
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            coil_q <= 3'h0;
            run_q <= 16'h0000;
            last_len_q <= 16'h0000;
            pulses_q <= 8'h00;
        end else begin
            coil_q <= line_in;
            if (line_in[0]) begin
                run_q <= run_q + 16'h0001;
            end else if (run_q != 16'h0000) begin
                last_len_q <= run_q; // Width of the finished pulse
                run_q <= 16'h0000;
                pulses_q <= pulses_q + 8'h01;
            end
        end
    end
endmodule // relay_model

// [bench/tb_top.sv]
// Purpose: Self-checking bench for the discrete output condition logic.
// Assumes: Short seconds tick (10 cycles) so service timing stays brief.
// Notes: APB master task plus decode and live-level scenarios.
`timescale 1ns/1ps
module tb_top;
    localparam int SEC = 10;
    localparam logic [11:0] SEL_TAB = 12'h88e;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic decode_done = 1'b0;
    logic match = 1'b0;
    logic mismatch = 1'b0;
    logic no_read = 1'b0;
    logic [2:0] trend_event = 3'h0;
    logic in_read_cycle = 1'b0;
    logic capture_active = 1'b0;
    logic diag_warning = 1'b0;
    logic continuous_mode = 1'b0; // Held off while service drive is used
    logic [13:0] grade_meas = 14'h3fff;
    logic [2:0] discrete_out;
    logic irq;
    logic [2:0] coil_q;
    logic [15:0] run_q;
    logic [15:0] last_len_q;
    logic [7:0] pulses_q;
    logic [31:0] rd;
    logic er;
    logic [7:0] p0;
    int err_count = 0;
    int samples_checked = 0;

    // 250 MHz clock
    always #2 clk = ~clk;

    dout_cond_top #(.SEC_CYCLES(SEC)) u_dout_cond_top (.clk(clk), .rst_b(rst_b), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .decode_done(decode_done), .match(match), .mismatch(mismatch),
        .no_read(no_read), .trend_event(trend_event), .in_read_cycle(in_read_cycle),
        .capture_active(capture_active), .diag_warning(diag_warning), .continuous_mode(continuous_mode),
        .grade_meas(grade_meas), .discrete_out(discrete_out), .irq(irq));

    relay_model u_relay_model (.clk(clk), .rst_b(rst_b), .line_in(discrete_out), .coil_q(coil_q),
        .run_q(run_q), .last_len_q(last_len_q), .pulses_q(pulses_q));

    // Verdict and end of run
    task automatic close_out();
        if (err_count == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Compare one value
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One APB transfer; waits for pready, only the watchdog ends a hang
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
        apb(a, 1'b0, 32'h0);
        chk(name, rd, exp);
    endtask

    // One decode strobe with outcome and measured grades
    task automatic decode(input logic [2:0] oc, input logic [13:0] g);
        @(posedge clk);
        match <= oc[0];
        mismatch <= oc[1];
        no_read <= oc[2];
        grade_meas <= g;
        decode_done <= 1'b1;
        @(posedge clk);
        decode_done <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    // Grade check on output 2 (quality selector)
    task automatic gcase(input logic [31:0] en, input logic [31:0] thr, input logic [13:0] g, input logic e);
        apb(8'h14, 1'b1, en);
        apb(8'h18, 1'b1, thr);
        decode(3'h1, g);
        chk("grade_out2", 32'(discrete_out[1]), 32'(e));
    endtask

    // Watchdog
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        close_out();
    end

    // Main sequence
    initial begin
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        rchk("cfg0", 8'h00, 32'h0);
        rchk("dpm_en0", 8'h04, 32'h0);
        rchk("dpm_thr0", 8'h08, 32'h2aaa);
        rchk("limit", 8'h30, 32'h12c);
        rchk("res", 8'h34, 32'h0);
        apb(8'h0c, 1'b0, 32'h0);
        chk("slverr", 32'(er), 32'h1);
        for (int c = 0; c < 4; c++) begin
            apb(8'h00, 1'b1, 32'(c));
            for (int o = 0; o < 3; o++) begin
                decode(3'(1 << o), 14'h3fff);
                chk("out1_sel", 32'(discrete_out[0]), 32'(SEL_TAB[c*3+o]));
                chk("out2_dflt", 32'(discrete_out[1]), 32'(SEL_TAB[o]));
            end
        end
        apb(8'h00, 1'b1, 32'h9);
        rchk("sel_keep", 8'h00, 32'h3);
        apb(8'h00, 1'b1, 32'h4);
        trend_event <= 3'h1;
        decode(3'h1, 14'h3fff);
        chk("trend", 32'(discrete_out[0]), 32'h1);
        trend_event <= 3'h0;
        for (int c = 6; c < 9; c++) begin
            apb(8'h00, 1'b1, 32'(c));
            for (int v = 1; v >= 0; v--) begin
                diag_warning <= (c == 6) && (v == 1);
                in_read_cycle <= (c == 7) && (v == 1);
                capture_active <= (c == 8) && (v == 1);
                repeat (3) @(posedge clk);
                chk("live", 32'(discrete_out[0]), 32'(v));
            end
        end
        apb(8'h10, 1'b1, 32'h5);
        gcase(32'h40, 32'h2aaa, 14'h1fff, 1'b1);
        gcase(32'h40, 32'h2aaa, 14'h2fff, 1'b0);
        gcase(32'h40, 32'h3aaa, 14'h2fff, 1'b1);
        gcase(32'h00, 32'h3aaa, 14'h0000, 1'b0);
        gcase(32'h01, 32'h2aa8, 14'h0000, 1'b0);
        gcase(32'h41, 32'h2aaa, 14'h3ffc, 1'b1);
        chk("out3_indep", 32'(discrete_out[2]), 32'h0);
        apb(8'h20, 1'b1, 32'h11);
        decode(3'h1, 14'h3fff);
        chk("diag_off", 32'(discrete_out[2]), 32'h0);
        diag_warning <= 1'b1;
        repeat (3) @(posedge clk);
        chk("diag_on", 32'(discrete_out[2]), 32'h1);
        diag_warning <= 1'b0;
        repeat (3) @(posedge clk);
        chk("diag_drop", 32'(discrete_out[2]), 32'h0);
        apb(8'h00, 1'b1, 32'h7);
        apb(8'h30, 1'b1, 32'h0);
        rchk("limit_min", 8'h30, 32'h1);
        apb(8'h30, 1'b1, 32'h2);
        apb(8'h3c, 1'b1, 32'h8);
        apb(8'h38, 1'b1, 32'hf);
        p0 = pulses_q;
        apb(8'h00, 1'b1, 32'h27);
        // The first pulse may be cut by the enable landing mid-hold; time the second
        for (int k = 0; k < 200 && 8'(pulses_q - p0) < 8'h02; k++) begin
            @(posedge clk);
        end
        chk("svc_pulses", 32'(8'(pulses_q - p0)), 32'h2);
        chk("svc_len", 32'(last_len_q), 32'(SEC));
        chk("irq_set", 32'(irq), 32'h1);
        apb(8'h38, 1'b1, 32'h8);
        repeat (3) @(posedge clk);
        chk("irq_clr", 32'(irq), 32'h0);
        // Minute resolution: hold lasts sixty short seconds
        apb(8'h34, 1'b1, 32'h1);
        p0 = pulses_q;
        for (int k = 0; k < 5000 && 8'(pulses_q - p0) < 8'h02; k++) begin
            @(posedge clk);
        end
        chk("svc_min_pulses", 32'(8'(pulses_q - p0)), 32'h2);
        chk("svc_min_len", 32'(last_len_q), 32'(SEC * 60));
        close_out();
    end
endmodule // tb_top
